/* File: design/sacc_top.sv */
// Conversion control for a 10-bit SAR converter behind an AHB-Lite slave.
//
// What this block does
// - Start on selectable edge of trigger pin.
// - Pin triggers only when select field chooses it.
// - Codes 0-7: input n against ground.
// - Codes A-D: even/odd input pairs differential.
// - Codes 8,9,E reserved; F common-mode trim.
// - Unity gain: track then hold, 16 periods.
// - Gain sixteen: three stages, 26.5 periods.
// - Amplify, then track, then hold, in order.
// - Track both channels, hold, convert 10 bits.
// - Same bit decisions for every gain.
// - Starts: software, continuous, timer, pin.
`timescale 1ns/1ns
module sacc_top
    import sacc_pkg::*;
#(
    parameter int unsigned SAR_CLK_HZ = sacc_pkg::SAR_CLK_HZ_DEF
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Interrupt.
    output logic IRQ,
    // Start sources and shared port pin.
    input wire logic TIMER_TRIG,
    input wire logic PORT0_BIT4_IN,
    output logic PORT0_BIT4_OUT,
    output logic PORT0_BIT4_OE,
    // Analog multiplexer and track/hold controls.
    output logic [2:0] SIG_CH,
    output logic [2:0] REF_CH,
    output logic [1:0] REF_SEL,
    output logic PGA_TRACK,
    output logic ADC_TRACK,
    output logic ADC_HOLD,
    // Comparator and trial code.
    input wire logic COMP_IN,
    output logic [9:0] DAC_CODE
);
    import sacc_pkg::*;

    // System cycles per half conversion-clock period, at least one.
    localparam int HALF_CYC = (CLK_HZ / (2 * SAR_CLK_HZ)) > 0 ? (CLK_HZ / (2 * SAR_CLK_HZ)) : 1;

    // Bus data-phase state.
    logic rd_q, rd_d, wr_q, wr_d, rdy_q, rdy_d;
    logic [7:0] adr_q, adr_d;
    logic [31:0] rdata_q, rdata_d;
    // Software-visible registers.
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [ST_W-1:0] stat_q, stat_d, mask_q, mask_d, stat_set;
    logic [1:0] port_q, port_d;
    logic [RES_W-1:0] res_q, res_d;
    logic irq_q, irq_d;
    logic sw_start, sw_start_q; // Software start strobe, registered so it sees the fields written with it.
    logic stat_clr; // Status read completes this cycle.
    // Sequencer state.
    sacc_state_e state_q, state_d;
    logic [5:0] ph_q, ph_d; // Half ticks spent in the current stage.
    logic [5:0] tcnt_q, tcnt_d; // Half ticks since the conversion began.
    logic [15:0] div_q, div_d;
    logic tick_q, tick_d;
    logic gain_q, gain_d;
    logic pin_q; // Pin level one cycle ago.
    logic [2:0] sig_q, sig_d, refc_q, refc_d;
    logic [1:0] rsel_q, rsel_d;
    logic pga_q, pga_d, trk_q, trk_d, hld_q, hld_d;
    logic sar_start, sar_done;
    logic [RES_W-1:0] sar_code, sar_res;
    // Decoded control fields and start requests.
    logic [2:0] trig;
    logic [3:0] chan;
    logic pin_edge, req, rsvd_code;

    assign trig = ctrl_q[TRIG_MSB:TRIG_LSB];
    assign chan = ctrl_q[CHAN_MSB:CHAN_LSB];

    // Bus slave: writes act in the data phase; reads take one wait state.
    always_comb
    begin
        rd_d = 1'b0;
        wr_d = 1'b0;
        adr_d = adr_q;
        rdy_d = 1'b1;
        rdata_d = rdata_q;
        stat_clr = 1'b0;
        if (rd_q)
        begin
            // Wait cycle: sample the register and finish the read.
            rdata_d = 32'h0000_0000;
            stat_clr = (adr_q == OFF_STATUS);
            case (adr_q)
                OFF_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
                OFF_RESULT: rdata_d[RES_W-1:0] = res_q;
                OFF_STATUS: rdata_d[ST_W-1:0] = stat_q;
                OFF_MASK: rdata_d[ST_W-1:0] = mask_q;
                OFF_PORT: rdata_d[PORT_PIN:0] = {PORT0_BIT4_IN, port_q};
                default: rdata_d = 32'h0000_0000; // Unmapped reads as zero.
            endcase
        end
        else if (HSEL && HREADY && HTRANS[1])
        begin
            // Address phase taken.
            adr_d = HADDR[7:0];
            rd_d = !HWRITE;
            wr_d = HWRITE;
            rdy_d = HWRITE;
        end
    end

    // Control, mask, port and status registers.
    always_comb
    begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        port_d = port_q;
        sw_start = 1'b0;
        if (wr_q)
        begin
            case (adr_q)
                OFF_CTRL:
                begin
                    ctrl_d = HWDATA[CTRL_W-1:0];
                    ctrl_d[START_BIT] = 1'b0; // Start bit never stored.
                    sw_start = HWDATA[START_BIT];
                end
                OFF_MASK: mask_d = HWDATA[ST_W-1:0];
                OFF_PORT: port_d = HWDATA[PORT_DIR:PORT_OUT];
                default: ctrl_d = ctrl_q; // Other writes are ignored.
            endcase
        end
        // A new event wins over the read that clears it.
        stat_d = (stat_clr ? '0 : stat_q) | stat_set;
        irq_d = |(stat_d & mask_d);
    end

    // Start requests from the four sources.
    always_comb
    begin
        // Pin edges count only when the select field routes the pin here.
        pin_edge = (trig == TRIG_PIN) && (ctrl_q[EDGE_BIT] ? (PORT0_BIT4_IN && !pin_q) : (!PORT0_BIT4_IN && pin_q));
        // Software, continuous, timer and pin sources.
        req = ((trig == TRIG_SOFT) && sw_start_q) || ((trig == TRIG_CONT) && (state_q == S_IDLE))
            || ((trig == TRIG_TIMER) && TIMER_TRIG) || pin_edge;
        rsvd_code = (chan > CH_SE_LAST) && (chan < CH_DIFF_FIRST) || (chan > CH_DIFF_LAST) && (chan != CH_TRIM);
    end

    // Conversion sequencer with its divider and multiplexer decode.
    always_comb
    begin
        state_d = state_q;
        ph_d = ph_q;
        gain_d = gain_q;
        sig_d = sig_q;
        refc_d = refc_q;
        rsel_d = rsel_q;
        res_d = res_q;
        stat_set = '0;
        sar_start = 1'b0;
        // Divider restarts with each conversion so stages are whole ticks.
        div_d = (state_q == S_IDLE || div_q == 16'(HALF_CYC - 1)) ? 16'h0000 : div_q + 16'h0001;
        tick_d = (state_q != S_IDLE) && (div_q == 16'(HALF_CYC - 1));
        tcnt_d = (state_q == S_IDLE) ? 6'h00 : tcnt_q + 6'(tick_q);
        case (state_q)
            S_IDLE:
            begin
                if (req && rsvd_code)
                begin
                    stat_set[ST_RSVD] = 1'b1; // Reserved code: no conversion.
                end
                else if (req)
                begin
                    gain_d = ctrl_q[GAIN_BIT];
                    ph_d = 6'h00;
                    state_d = ctrl_q[GAIN_BIT] ? S_AMP : S_TRACK;
                    if (chan <= CH_SE_LAST)
                    begin
                        sig_d = chan[2:0]; // Single-ended against ground.
                        refc_d = 3'h0;
                        rsel_d = REF_GND;
                    end
                    else if (chan == CH_TRIM)
                    begin
                        sig_d = 3'h0; // Both sides on the common-mode source.
                        refc_d = 3'h0;
                        rsel_d = REF_CM;
                    end
                    else
                    begin
                        sig_d = {chan[1:0] - 2'h2, 1'b0}; // Even input signal, odd reference.
                        refc_d = {chan[1:0] - 2'h2, 1'b1};
                        rsel_d = REF_PAIR;
                    end
                end
            end
            S_AMP:
            begin
                // Gain stage tracks and holds the difference first.
                if (tick_q)
                begin
                    ph_d = ph_q + 6'h01;
                    if (ph_q == HALF_AMP - 6'h01)
                    begin
                        ph_d = 6'h00;
                        state_d = S_TRACK;
                    end
                end
            end
            S_TRACK:
            begin
                // Both input capacitors track, then hold starts the bit decisions.
                if (tick_q)
                begin
                    ph_d = ph_q + 6'h01;
                    if (ph_q == HALF_TRACK - 6'h01)
                    begin
                        state_d = S_CONV;
                        sar_start = 1'b1;
                    end
                end
            end
            S_CONV:
            begin
                if (sar_done)
                begin
                    res_d = sar_res;
                    stat_set[ST_DONE] = 1'b1;
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
        // A start that finds the converter busy is dropped and flagged.
        if (req && state_q != S_IDLE && trig != TRIG_CONT)
        begin
            stat_set[ST_OVR] = 1'b1;
        end
        pga_d = (state_d == S_AMP);
        trk_d = (state_d == S_TRACK);
        hld_d = (state_d == S_CONV);
    end

    // Bit decisions shared by both gain settings.
    sacc_sar #(.W(RES_W)) u_sar (
        .clk(CLK),
        .rst(SYS_RST),
        .tick(tick_q),
        .start(sar_start),
        .comp(COMP_IN),
        .code_q(sar_code),
        .result_q(sar_res),
        .done_q(sar_done)
    );

    // All state registers.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            adr_q <= 8'h00;
            rdy_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            ctrl_q <= CTRL_RST;
            mask_q <= MASK_RST;
            stat_q <= '0;
            port_q <= PORT_RST;
            res_q <= '0;
            irq_q <= 1'b0;
            sw_start_q <= 1'b0;
            state_q <= S_IDLE;
            ph_q <= 6'h00;
            tcnt_q <= 6'h00;
            div_q <= 16'h0000;
            tick_q <= 1'b0;
            gain_q <= 1'b0;
            pin_q <= 1'b0;
            sig_q <= 3'h0;
            refc_q <= 3'h0;
            rsel_q <= REF_GND;
            pga_q <= 1'b0;
            trk_q <= 1'b0;
            hld_q <= 1'b0;
        end
        else
        begin
            rd_q <= rd_d;
            wr_q <= wr_d;
            adr_q <= adr_d;
            rdy_q <= rdy_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            port_q <= port_d;
            res_q <= res_d;
            irq_q <= irq_d;
            sw_start_q <= sw_start;
            state_q <= state_d;
            ph_q <= ph_d;
            tcnt_q <= tcnt_d;
            div_q <= div_d;
            tick_q <= tick_d;
            gain_q <= gain_d;
            pin_q <= PORT0_BIT4_IN;
            sig_q <= sig_d;
            refc_q <= refc_d;
            rsel_q <= rsel_d;
            pga_q <= pga_d;
            trk_q <= trk_d;
            hld_q <= hld_d;
        end
    end

    // Outputs straight from flip-flops, HRESP tied low; the pin direction is left to software.
    assign HRDATA = rdata_q;
    assign HREADYOUT = rdy_q;
    assign HRESP = 1'b0;
    assign IRQ = irq_q;
    assign PORT0_BIT4_OUT = port_q[PORT_OUT];
    assign PORT0_BIT4_OE = port_q[PORT_DIR];
    assign SIG_CH = sig_q;
    assign REF_CH = refc_q;
    assign REF_SEL = rsel_q;
    assign PGA_TRACK = pga_q;
    assign ADC_TRACK = trk_q;
    assign ADC_HOLD = hld_q;
    assign DAC_CODE = sar_code;

    // Checks on the sequencer.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    chk_pin_edge_start: assert property ((state_q == S_IDLE) && pin_edge && !rsvd_code
        |=> state_q != S_IDLE) else $error("pin edge did not start");
    chk_pin_not_routed: assert property ((state_q == S_IDLE) && (trig == TRIG_SOFT) && !sw_start_q
        |=> state_q == S_IDLE) else $error("start without a routed source");
    chk_se_decode: assert property ((state_q == S_IDLE) && req && (chan <= CH_SE_LAST)
        |=> (REF_SEL == REF_GND) && (SIG_CH == $past(chan[2:0]))) else $error("bad single-ended decode");
    chk_diff_decode: assert property ((state_q == S_IDLE) && req && (chan == CH_DIFF_LAST)
        |=> (REF_SEL == REF_PAIR) && (SIG_CH == 3'h6) && (REF_CH == 3'h7)) else $error("bad pair decode");
    chk_rsvd_block: assert property ((state_q == S_IDLE) && req && rsvd_code
        |=> (state_q == S_IDLE) && stat_q[ST_RSVD]) else $error("reserved code converted");
    chk_unity_len: assert property ((state_q == S_CONV) && sar_done && !gain_q
        |-> tcnt_q == HALF_UNITY) else $error("unity conversion length wrong");
    chk_gain_len: assert property ((state_q == S_CONV) && sar_done && gain_q
        |-> tcnt_q == HALF_GAIN) else $error("gain conversion length wrong");
    chk_stage_order: assert property ((state_q == S_AMP) ##1 (state_q != S_AMP)
        |-> state_q == S_TRACK) else $error("amplify not followed by track");
    chk_hold_after: assert property ($rose(ADC_HOLD) |-> $past(ADC_TRACK) && !ADC_TRACK)
        else $error("hold without preceding track");
    chk_result_latch: assert property ((state_q == S_CONV) && sar_done
        |=> (res_q == $past(sar_res)) && stat_q[ST_DONE]) else $error("result not latched");
    cov_unity: cover property ((state_q == S_CONV) && sar_done && !gain_q);
    cov_gain: cover property ((state_q == S_CONV) && sar_done && gain_q);
    cov_pin: cover property ((state_q == S_IDLE) && pin_edge);
    cov_overrun: cover property (stat_set[ST_OVR]);
endmodule // sacc_top

/* File: design/sacc_pkg.sv */
// Shared constants and types of the converter control block.
package sacc_pkg;
    // System clock rate and default conversion clock rate.
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SAR_CLK_HZ_DEF = 4_000_000;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RESULT = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_PORT = 8'h10;
    // Fields of the converter control word.
    localparam int TRIG_LSB = 0;
    localparam int TRIG_MSB = 2;
    localparam int EDGE_BIT = 3;
    localparam int GAIN_BIT = 4;
    localparam int START_BIT = 5;
    localparam int CHAN_LSB = 11;
    localparam int CHAN_MSB = 14;
    localparam int CTRL_W = 15;
    localparam logic [14:0] CTRL_RST = 15'h0000;
    // Start source codes held in the trigger-select field.
    localparam logic [2:0] TRIG_SOFT = 3'h0;
    localparam logic [2:0] TRIG_CONT = 3'h1;
    localparam logic [2:0] TRIG_TIMER = 3'h2;
    localparam logic [2:0] TRIG_PIN = 3'h3;
    // Status and mask bits.
    localparam int ST_DONE = 0;
    localparam int ST_OVR = 1;
    localparam int ST_RSVD = 2;
    localparam int ST_W = 3;
    localparam logic [2:0] MASK_RST = 3'h0;
    // Port bit 4 register fields.
    localparam int PORT_OUT = 0;
    localparam int PORT_DIR = 1;
    localparam int PORT_PIN = 2;
    localparam logic [1:0] PORT_RST = 2'h0;
    // Channel codes.
    localparam logic [3:0] CH_SE_LAST = 4'h7;
    localparam logic [3:0] CH_DIFF_FIRST = 4'hA;
    localparam logic [3:0] CH_DIFF_LAST = 4'hD;
    localparam logic [3:0] CH_TRIM = 4'hF;
    // Reference selections toward the input multiplexer.
    localparam logic [1:0] REF_GND = 2'h0;
    localparam logic [1:0] REF_PAIR = 2'h1;
    localparam logic [1:0] REF_CM = 2'h2;
    // Stage and whole-conversion lengths in half conversion-clock periods.
    localparam logic [5:0] HALF_AMP = 6'h15;
    localparam logic [5:0] HALF_TRACK = 6'h0C;
    localparam logic [5:0] HALF_UNITY = 6'h20;
    localparam logic [5:0] HALF_GAIN = 6'h35;
    // Result width.
    localparam int RES_W = 10;
    // Conversion sequencer states.
    typedef enum logic [1:0] {S_IDLE, S_AMP, S_TRACK, S_CONV} sacc_state_e;
endpackage

/* File: design/sacc_sar.sv */
// Successive-approximation bit-decision engine.
`timescale 1ns/1ns
module sacc_sar #(
    parameter int W = 10
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Half-period tick, start pulse and comparator.
    input wire logic tick,
    input wire logic start,
    input wire logic comp,
    // Trial code, result and completion pulse.
    output logic [W-1:0] code_q,
    output logic [W-1:0] result_q,
    output logic done_q
);
    logic [W-1:0] code_d, result_d;
    logic [$clog2(W)-1:0] bit_q, bit_d; // Bit under trial.
    logic half_q, half_d; // Low: settle half, high: decide half.
    logic run_q, run_d;
    logic done_d;

    // One bit per conversion-clock period, MSB first, same for every gain.
    always_comb
    begin
        code_d = code_q;
        result_d = result_q;
        bit_d = bit_q;
        half_d = half_q;
        run_d = run_q;
        done_d = 1'b0;
        if (start)
        begin
            // Trial begins at mid-scale.
            code_d = '0;
            code_d[W-1] = 1'b1;
            bit_d = ($clog2(W))'(W - 1);
            half_d = 1'b0;
            run_d = 1'b1;
        end
        else if (run_q && tick)
        begin
            if (!half_q)
            begin
                half_d = 1'b1;
            end
            else
            begin
                // Comparator low means the trial overshot.
                if (!comp)
                begin
                    code_d[bit_q] = 1'b0;
                end
                half_d = 1'b0;
                if (bit_q == '0)
                begin
                    run_d = 1'b0;
                    done_d = 1'b1;
                    result_d = code_d;
                end
                else
                begin
                    bit_d = bit_q - 1'b1;
                    code_d[bit_d] = 1'b1;
                end
            end
        end
    end

    // Registers of the engine.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            code_q <= '0;
            result_q <= '0;
            bit_q <= '0;
            half_q <= 1'b0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            code_q <= code_d;
            result_q <= result_d;
            bit_q <= bit_d;
            half_q <= half_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end

    // The completion pulse comes only once the engine has stopped running.
    chk_sar_done: assert property (@(posedge clk) disable iff (rst)
        done_q |-> !run_q) else $error("engine still running at done");
endmodule // sacc_sar

/* File: verification/sacc_analog_model.sv */
// Behavioural model of the analog multiplexer inputs and the comparator.
`timescale 1ns/1ns
module sacc_analog_model
    import sacc_pkg::*;
(
    // Clock and comparator speed choice.
    input wire logic clk,
    input wire logic slow,
    // Multiplexer selection and trial code.
    input wire logic [2:0] sig_ch,
    input wire logic [2:0] ref_ch,
    input wire logic [1:0] ref_sel,
    input wire logic [9:0] dac_code,
    // Comparator decision, high when the input is at least the trial code.
    output logic comp
);
    int v; // Differential input in result codes.
    logic comp_q; // Late copy of the decision for a slow comparator.
    // Each input pin sits at a level that grows with the square of its number.
    function automatic int lvl(input int c);
        return c * c * 16 + 40;
    endfunction
    // Signal minus reference, centred at mid scale for pairs and trim.
    always_comb
    begin
        if (ref_sel === REF_GND)
            v = lvl(sig_ch);
        else if (ref_sel === REF_PAIR)
            v = 512 + lvl(sig_ch) - lvl(ref_ch);
        else
            v = 512;
    end
    // A slow comparator answers one clock late, still inside a settle half.
    always_ff @(posedge clk)
        comp_q <= (v >= dac_code);
    assign comp = slow ? comp_q : (v >= dac_code);
endmodule // sacc_analog_model

/* File: verification/sacc_top_tb_top.sv */
// Self-checking testbench of the converter control block.
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("mismatch %s exp %0h got %0h", nm, e, g); \
        end \
    end
module sacc_top_tb_top;
    import sacc_pkg::*;
    localparam int unsigned SAR_HZ = 25_000_000; // Short half periods.
    localparam int HC = CLK_HZ / SAR_HZ / 2; // Clocks per half period.
    logic clk, sys_rst, hsel, hwrite, timer_trig, ext_lvl, slow;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, ref_sel;
    logic [2:0] hsize, sig_ch, ref_ch;
    logic hreadyout, hresp, irq, p_out, p_oe, pga_tr, adc_tr, adc_hold, comp;
    logic [9:0] dac;
    wire logic pin = p_oe ? p_out : ext_lvl; // Pin level from both drivers.
    int n_errors, cmp_count, cyc = 0;
    int t[3]; // Cycles spent in amplify, track and hold.
    sacc_top #(.SAR_CLK_HZ(SAR_HZ)) dut (.CLK(clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq), .TIMER_TRIG(timer_trig),
        .PORT0_BIT4_IN(pin), .PORT0_BIT4_OUT(p_out), .PORT0_BIT4_OE(p_oe), .SIG_CH(sig_ch),
        .REF_CH(ref_ch), .REF_SEL(ref_sel), .PGA_TRACK(pga_tr), .ADC_TRACK(adc_tr),
        .ADC_HOLD(adc_hold), .COMP_IN(comp), .DAC_CODE(dac));
    sacc_analog_model mdl (.clk(clk), .slow(slow), .sig_ch(sig_ch), .ref_ch(ref_ch),
        .ref_sel(ref_sel), .dac_code(dac), .comp(comp));
    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One AHB-Lite single word transfer; read data lands in rd.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp);
    endtask
    // Selects one stage output.
    function automatic logic stage(input int w);
        return w == 0 ? pga_tr : (w == 1 ? adc_tr : adc_hold);
    endfunction
    // Waits for a conversion to begin and counts each stage in turn.
    task automatic measure();
        #1;
        for (int i = 0; i < 20 && pga_tr !== 1'b1 && adc_tr !== 1'b1; i++) @(posedge clk) #1;
        foreach (t[w])
        begin
            t[w] = 0;
            while (stage(w) === 1'b1 && t[w] < 500)
            begin
                t[w]++;
                @(posedge clk) #1;
            end
        end
    endtask
    // Checks that no conversion starts for a while.
    task automatic quiet();
        logic busy;
        busy = 1'b0;
        repeat (20)
        begin
            @(posedge clk) #1;
            busy |= pga_tr | adc_tr;
        end
        `CHK("quiet", 1'b0, busy);
    endtask
    // Expected result from the pin levels that the model holds.
    function automatic int expv(input int c);
        if (c <= 7)
            return c * c * 16 + 40;
        if (c == 15)
            return 512;
        return 512 + (2 * (c - 10)) ** 2 * 16 - (2 * (c - 10) + 1) ** 2 * 16;
    endfunction
    // Reset values, read-back, port drive and an unmapped place.
    task automatic regs();
        logic [7:0] offs[5] = '{OFF_CTRL, OFF_RESULT, OFF_STATUS, OFF_MASK, OFF_PORT};
        foreach (offs[i])
        begin
            ahb(1'b0, offs[i], 32'h0);
            `CHK("reset value", 32'h0, rd);
        end
        ahb(1'b1, 8'h20, 32'hFFFFFFFF);
        ahb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 32'h0, rd);
        ahb(1'b1, OFF_CTRL, 32'h00005818);
        ahb(1'b0, OFF_CTRL, 32'h0);
        `CHK("ctrl", 32'h00005818, rd);
        ahb(1'b1, OFF_CTRL, 32'h0);
        ahb(1'b1, OFF_PORT, 32'h3);
        ahb(1'b0, OFF_PORT, 32'h0);
        `CHK("port", 32'h7, rd);
        ahb(1'b1, OFF_MASK, 32'h1);
        ahb(1'b0, OFF_MASK, 32'h0);
        `CHK("mask", 32'h1, rd);
    endtask
    // Software start on one channel code, checking mux, stages, result and interrupt.
    task automatic conv(input logic [3:0] code, input logic gain);
        logic [1:0] k;
        k = 2'(code - 4'hA);
        ahb(1'b1, OFF_CTRL, (32'(code) << CHAN_LSB) | (32'(gain) << GAIN_BIT) | 32'h20);
        measure();
        if (code <= CH_SE_LAST)
        begin
            `CHK("sig", code[2:0], sig_ch);
            `CHK("ref sel", REF_GND, ref_sel);
        end
        else if (code == CH_TRIM)
        begin
            `CHK("ref sel", REF_CM, ref_sel);
        end
        else
        begin
            `CHK("sig", {k, 1'b0}, sig_ch);
            `CHK("ref", {k, 1'b1}, ref_ch);
            `CHK("ref sel", REF_PAIR, ref_sel);
        end
        // The registered tick lengthens the first stage and the completion cycle the hold.
        `CHK("amp", gain ? int'(HALF_AMP) * HC + 1 : 0, t[0]);
        `CHK("track", int'(HALF_TRACK) * HC + (gain ? 0 : 1), t[1]);
        `CHK("hold", 20 * HC + 1, t[2]);
        `CHK("total", gain ? 53 * HC + 2 : 32 * HC + 2, t[0] + t[1] + t[2]);
        repeat (4) @(posedge clk);
        ahb(1'b0, OFF_RESULT, 32'h0);
        `CHK("result", 32'(expv(code)), rd);
        `CHK("irq", 1'b1, irq);
        ahb(1'b0, OFF_STATUS, 32'h0);
        `CHK("status", 32'h1, rd);
        @(posedge clk) #1;
        `CHK("irq clear", 1'b0, irq);
    endtask
    // Reserved codes raise the refusal flag and start nothing.
    task automatic reserved();
        logic [3:0] codes[3] = '{4'h8, 4'h9, 4'hE};
        foreach (codes[i])
        begin
            ahb(1'b1, OFF_CTRL, (32'(codes[i]) << CHAN_LSB) | 32'h20);
            quiet();
            ahb(1'b0, OFF_STATUS, 32'h0);
            `CHK("reserved", 32'h4, rd);
        end
    endtask
    // Pin trigger on either edge, and the pin ignored outside pin mode.
    task automatic pins();
        ahb(1'b1, OFF_PORT, 32'h0);
        ahb(1'b1, OFF_CTRL, 32'h0);
        ext_lvl <= 1'b1;
        quiet();
        @(posedge clk) ext_lvl <= 1'b0;
        quiet();
        ahb(1'b1, OFF_CTRL, 32'(TRIG_PIN) | 32'h8);
        ext_lvl <= 1'b1;
        measure();
        `CHK("rise start", int'(HALF_TRACK) * HC + 1, t[1]);
        @(posedge clk) ext_lvl <= 1'b0;
        quiet();
        ahb(1'b1, OFF_CTRL, 32'(TRIG_PIN));
        ext_lvl <= 1'b1;
        quiet();
        @(posedge clk) ext_lvl <= 1'b0;
        measure();
        `CHK("fall start", int'(HALF_TRACK) * HC + 1, t[1]);
        ahb(1'b0, OFF_STATUS, 32'h0);
    endtask
    // Continuous and timer start sources.
    task automatic sources();
        ahb(1'b1, OFF_CTRL, 32'(TRIG_CONT) | 32'h0800);
        measure();
        measure();
        `CHK("restart", 32 * HC + 2, t[1] + t[2]);
        ahb(1'b1, OFF_CTRL, 32'(TRIG_TIMER));
        repeat (100) @(posedge clk);
        ahb(1'b0, OFF_STATUS, 32'h0);
        quiet();
        @(posedge clk) timer_trig <= 1'b1;
        @(posedge clk) timer_trig <= 1'b0;
        measure();
        `CHK("timer start", 32 * HC + 2, t[1] + t[2]);
    endtask
    // Free-running clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cuts a hang short.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_errors++;
            conclude();
        end
    end
    // Main sequence.
    initial
    begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        timer_trig = 1'b0;
        ext_lvl = 1'b0;
        slow = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        regs();
        for (int c = 0; c < 16; c++)
            if (c != 8 && c != 9 && c != 14)
                conv(4'(c), 1'b0);
        reserved();
        slow <= 1'b1;
        conv(4'h5, 1'b1);
        conv(4'hB, 1'b1);
        slow <= 1'b0;
        pins();
        sources();
        conclude();
    end
endmodule // sacc_top_tb_top
